// ===== logic/dcf_input_fifo.sv
// dcf_input_fifo: split-lane input queue, written from pins, read from a data port.
// assumes: lane clocks are far slower than clk_i (bench uses 125 ns) so that
// sampling them after two flops finds every rising edge.
`timescale 1ns/1ps
// Function
// - capacity is BLOCKS times 512 bytes, at least one block
// - 16-bit entries, one word queue or two independent byte queues
// - lane clocks are asynchronous; all pin signals cross via two flops
// - each queue returns data in write order
// - full raised while lane cannot accept; writer holds request off
// - word mode uses only low-lane controls; high-lane clock, request and reset pins ignored
// - rising lane clock with request high stores that lane's byte
// - full output is one while lane queue is full
// - lane reset pin empties that queue only, control bits kept
// - data read pops oldest entry, 8 bits split, 16 bits word
// - control port 8 bits; offset 0 reads status, writes command
// - status bit 7 shows split setting
// - status bits 2,1 not-empty high, low; bit 0 not-full
// - status bits 4,3 show high and low interrupt enables
// - command bits 7/6 set/clear high enable, 5/4 low enable
// - command bits 3/2 split/word mode, 1/0 flush high/low
// - offset 1 reads size in 512-byte pages
// - offsets 2,3 read low, high used counts saturating at 255
// - interrupt when queue not empty and its enable is one
module dcf_input_fifo #(
  parameter int BLOCKS = 1
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // pin side
  input  wire logic [15:0] lane_data_i,
  input  wire logic [1:0]  lane_write_clock_i,
  input  wire logic [1:0]  lane_wrreq_i,
  input  wire logic [1:0]  lane_reset_i,
  output logic      [1:0]  lane_full_o,
  // data read port
  input  wire logic        data_rd_i,
  input  wire logic        data_lane_i,
  output logic      [15:0] data_rdata_o,
  // control/status port
  input  wire logic [1:0]  csr_addr_i,
  input  wire logic        csr_rd_i,
  input  wire logic        csr_wr_i,
  input  wire logic [7:0]  csr_wdata_i,
  output logic      [7:0]  csr_rdata_o,
  output logic             irq_o
);

  localparam int LANES = dcf_pkg::LANES;
  localparam int LW    = dcf_pkg::LANE_W;
  localparam int DEPTH = (BLOCKS < 1 ? 1 : BLOCKS) * dcf_pkg::PAGE_BYTES / dcf_pkg::ENTRY_BYTES;
  localparam int AW    = $clog2(DEPTH);
  localparam int CW    = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [7:0]    PAGES_C = 8'(BLOCKS < 1 ? 1 : BLOCKS);

  function automatic logic [7:0] sat_used(input logic [CW-1:0] cnt);
    if (cnt >= CW'(dcf_pkg::USED_SAT))
    begin
      return dcf_pkg::USED_SAT;
    end
    return 8'(cnt);
  endfunction : sat_used

  // pin synchronisers
  logic [15:0]      data_s;
  logic [1:0]       wclk_s;
  logic [1:0]       wreq_s;
  logic [1:0]       rst_s;
  logic [1:0]       wclk_prev_reg;
  logic [1:0]       wclk_rise;

  // two-flop crossing of every pin input
  dcf_sync2 #(.W(22)) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i ({lane_data_i, lane_write_clock_i, lane_wrreq_i, lane_reset_i}),
    .sync_o  ({data_s, wclk_s, wreq_s, rst_s})
  );

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wclk_prev_reg <= '0;
    end
    else
    begin
      wclk_prev_reg <= wclk_s;
    end
  end

  assign wclk_rise = wclk_s & ~wclk_prev_reg;

  // control state
  logic             split_reg;
  logic             ien_hi_reg;
  logic             ien_lo_reg;
  logic             cmd_wr;

  assign cmd_wr = csr_wr_i && (csr_addr_i == dcf_pkg::CSR_STATUS);

  // lane mode select; word wins if both bits set
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      split_reg <= dcf_pkg::SPLIT_RESET;
    end
    else if (cmd_wr && csr_wdata_i[dcf_pkg::CMD_WORD])
    begin
      split_reg <= 1'b0;
    end
    else if (cmd_wr && csr_wdata_i[dcf_pkg::CMD_SPLIT])
    begin
      split_reg <= 1'b1;
    end
  end

  // set/clear interrupt enables; clear wins if both set
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ien_hi_reg <= 1'b0;
      ien_lo_reg <= 1'b0;
    end
    else if (cmd_wr)
    begin
      if (csr_wdata_i[dcf_pkg::CMD_CLR_IEN_HI])
      begin
        ien_hi_reg <= 1'b0;
      end
      else if (csr_wdata_i[dcf_pkg::CMD_SET_IEN_HI])
      begin
        ien_hi_reg <= 1'b1;
      end
      if (csr_wdata_i[dcf_pkg::CMD_CLR_IEN_LO])
      begin
        ien_lo_reg <= 1'b0;
      end
      else if (csr_wdata_i[dcf_pkg::CMD_SET_IEN_LO])
      begin
        ien_lo_reg <= 1'b1;
      end
    end
  end

  // per-lane queue state
  logic [CW-1:0]    count_reg [LANES];
  logic [LANES-1:0] lane_full;
  logic [LANES-1:0] nonempty;
  logic [LANES-1:0] wr_fire;
  logic [LANES-1:0] pop;
  logic [LANES-1:0] flush;
  logic [LW-1:0]    lane_q [LANES];

  // word mode drives both lanes from the low-lane controls
  // store on sampled rising edge with request
  // a request is dropped while its gating lane is full; word mode gates both lanes on the low lane
  assign wr_fire[0] = wclk_rise[0] && wreq_s[0] && !lane_full[0];
  assign wr_fire[1] = split_reg ? (wclk_rise[1] && wreq_s[1] && !lane_full[1]) : wr_fire[0];

  // pop the selected lane in split mode, both lanes in word mode
  // a lane is popped only while not empty; word mode gates both lanes on the low lane
  assign pop[0] = data_rd_i && nonempty[0] && (!split_reg || !data_lane_i);
  assign pop[1] = split_reg ? (data_rd_i && nonempty[1] && data_lane_i) : pop[0];

  // reset pin empties storage only; command flush per lane
  assign flush[0] = rst_s[0] || (cmd_wr && csr_wdata_i[dcf_pkg::CMD_FLUSH_LO]);
  assign flush[1] = (split_reg ? rst_s[1] : rst_s[0]) || (cmd_wr && csr_wdata_i[dcf_pkg::CMD_FLUSH_HI]);

  for (genvar g = 0; g < LANES; g++)
  begin : g_lane
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_next;

    assign lane_full[g] = (count_reg[g] == DEPTH_C);
    assign nonempty[g]  = (count_reg[g] != '0);

    always_comb
    begin
      count_next = count_reg[g];
      if (flush[g])
      begin
        count_next = '0;
      end
      else if (wr_fire[g] && !pop[g])
      begin
        count_next = CW'(count_reg[g] + 1'b1);
      end
      else if (pop[g] && !wr_fire[g])
      begin
        count_next = CW'(count_reg[g] - 1'b1);
      end
    end

    always_ff @(posedge clk_i)
    begin
      if (reset_i || flush[g])
      begin
        wr_ptr_reg   <= '0;
        rd_ptr_reg   <= '0;
        count_reg[g] <= '0;
      end
      else
      begin
        count_reg[g] <= count_next;
        if (wr_fire[g])
        begin
          wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr_reg + 1'b1);
        end
        if (pop[g])
        begin
          rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr_reg + 1'b1);
        end
      end
    end

    // full output follows next count, never a cycle late
    always_ff @(posedge clk_i)
    begin
      if (reset_i)
      begin
        lane_full_o[g] <= 1'b0;
      end
      else
      begin
        lane_full_o[g] <= (count_next == DEPTH_C);
      end
    end

    // each lane is a byte-wide store
    dcf_lane_ram #(.DEPTH(DEPTH), .AW(AW), .DW(LW)) u_ram (
      .clk_i     (clk_i),
      .wr_en_i   (wr_fire[g] && !flush[g]),
      .wr_addr_i (wr_ptr_reg),
      .wr_data_i (data_s[g*LW +: LW]),
      .rd_en_i   (pop[g]),
      .rd_addr_i (rd_ptr_reg),
      .rd_data_o (lane_q[g])
    );
  end

  // read data assembly, one cycle after the memory answers
  logic [1:0] pop_d_reg;
  logic       pop_split_reg;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pop_d_reg     <= '0;
      pop_split_reg <= 1'b0;
    end
    else
    begin
      pop_d_reg     <= pop;
      pop_split_reg <= split_reg;
    end
  end

  // split mode returns one byte in the low bits
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      data_rdata_o <= '0;
    end
    else if (pop_split_reg && pop_d_reg[1])
    begin
      data_rdata_o <= {dcf_pkg::BYTE_ZERO, lane_q[1]};
    end
    else if (pop_split_reg && pop_d_reg[0])
    begin
      data_rdata_o <= {dcf_pkg::BYTE_ZERO, lane_q[0]};
    end
    else if (pop_d_reg[0])
    begin
      data_rdata_o <= {lane_q[1], lane_q[0]};
    end
  end

  // status byte
  logic [7:0] status;
  logic       not_full;

  // in split mode "not full" means neither lane is full
  assign not_full = split_reg ? !(lane_full[0] || lane_full[1]) : !lane_full[0];

  always_comb
  begin
    status = '0;
    status[dcf_pkg::ST_SPLIT]  = split_reg;
    status[dcf_pkg::ST_IEN_HI] = ien_hi_reg;
    status[dcf_pkg::ST_IEN_LO] = ien_lo_reg;
    status[dcf_pkg::ST_NE_HI]  = nonempty[1];
    status[dcf_pkg::ST_NE_LO]  = nonempty[0];
    status[dcf_pkg::ST_NFULL]  = not_full;
  end

  // byte-wide reads, answer one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      csr_rdata_o <= '0;
    end
    else if (csr_rd_i)
    begin
      case (csr_addr_i)
        dcf_pkg::CSR_STATUS:  csr_rdata_o <= status;
        dcf_pkg::CSR_SIZE:    csr_rdata_o <= PAGES_C;
        dcf_pkg::CSR_USED_LO: csr_rdata_o <= sat_used(count_reg[0]);
        dcf_pkg::CSR_USED_HI: csr_rdata_o <= sat_used(count_reg[1]);
        default:              csr_rdata_o <= '0;
      endcase
    end
  end

  // level interrupt, OR of enabled not-empty conditions
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= (ien_hi_reg && nonempty[1]) || (ien_lo_reg && nonempty[0]);
    end
  end

endmodule : dcf_input_fifo

// ===== logic/dcf_pkg.sv
// dcf_pkg: shared constants of the split-lane input queue.
// assumes: nothing; every user refers to names as dcf_pkg::name.
package dcf_pkg;

  localparam int          PAGE_BYTES  = 512;
  localparam int          ENTRY_BYTES = 2;
  localparam int          LANES       = 2;
  localparam int          LANE_W      = 8;

  // control/status offsets
  localparam logic [1:0]  CSR_STATUS  = 2'h0;
  localparam logic [1:0]  CSR_SIZE    = 2'h1;
  localparam logic [1:0]  CSR_USED_LO = 2'h2;
  localparam logic [1:0]  CSR_USED_HI = 2'h3;

  // status bits
  localparam int          ST_SPLIT    = 7;
  localparam int          ST_IEN_HI   = 4;
  localparam int          ST_IEN_LO   = 3;
  localparam int          ST_NE_HI    = 2;
  localparam int          ST_NE_LO    = 1;
  localparam int          ST_NFULL    = 0;

  // command bits
  localparam int          CMD_SET_IEN_HI = 7;
  localparam int          CMD_CLR_IEN_HI = 6;
  localparam int          CMD_SET_IEN_LO = 5;
  localparam int          CMD_CLR_IEN_LO = 4;
  localparam int          CMD_SPLIT      = 3;
  localparam int          CMD_WORD       = 2;
  localparam int          CMD_FLUSH_HI   = 1;
  localparam int          CMD_FLUSH_LO   = 0;

  localparam logic [7:0]  USED_SAT    = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic        SPLIT_RESET = 1'b0;

endpackage : dcf_pkg

// ===== logic/dcf_sync2.sv
// dcf_sync2: two-flop synchroniser for a vector of independent levels.
// assumes: each bit is a level from outside clk_i's domain.
`timescale 1ns/1ps
module dcf_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] stage1_reg;

  // the first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      stage1_reg <= '0;
      sync_o     <= '0;
    end
    else
    begin
      stage1_reg <= async_i;
      sync_o     <= stage1_reg;
    end
  end

endmodule : dcf_sync2

// ===== logic/dcf_lane_ram.sv
// dcf_lane_ram: one byte lane of queue storage, one write port, one read port.
// assumes: caller keeps addresses in range; read data is registered on rd_en_i.
`timescale 1ns/1ps
module dcf_lane_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8,
  parameter int DW    = 8
) (
  input  wire logic          clk_i,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [DW-1:0] wr_data_i,
  input  wire logic          rd_en_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [DW-1:0] rd_data_o
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rd_en_i)
    begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule : dcf_lane_ram

// ===== bench/dcf_input_fifo_asserts.sv
// dcf_input_fifo_asserts: port-level checker for the split-lane input queue.
// assumes: bound to dcf_input_fifo; sees its ports only.
`timescale 1ns/1ps
module dcf_input_fifo_asserts #(
  parameter int BLOCKS = 1
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [15:0] lane_data_i,
  input  wire logic [1:0]  lane_write_clock_i,
  input  wire logic [1:0]  lane_wrreq_i,
  input  wire logic [1:0]  lane_reset_i,
  input  wire logic [1:0]  lane_full_o,
  input  wire logic        data_rd_i,
  input  wire logic        data_lane_i,
  input  wire logic [15:0] data_rdata_o,
  input  wire logic [1:0]  csr_addr_i,
  input  wire logic        csr_rd_i,
  input  wire logic        csr_wr_i,
  input  wire logic [7:0]  csr_wdata_i,
  input  wire logic [7:0]  csr_rdata_o,
  input  wire logic        irq_o
);
  logic split_q;
  logic hi_en_q;
  logic lo_en_q;
  wire  cmd = csr_wr_i && (csr_addr_i == dcf_pkg::CSR_STATUS);
  wire  rd0 = csr_rd_i && (csr_addr_i == dcf_pkg::CSR_STATUS);
  wire  rd1 = csr_rd_i && (csr_addr_i == dcf_pkg::CSR_SIZE);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // shadow of the command effects; clear and word win over set and split
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      split_q <= 1'b0;
      hi_en_q <= 1'b0;
      lo_en_q <= 1'b0;
    end
    else if (cmd)
    begin
      split_q <= csr_wdata_i[2] ? 1'b0 : (csr_wdata_i[3] ? 1'b1 : split_q);
      hi_en_q <= csr_wdata_i[6] ? 1'b0 : (csr_wdata_i[7] ? 1'b1 : hi_en_q);
      lo_en_q <= csr_wdata_i[4] ? 1'b0 : (csr_wdata_i[5] ? 1'b1 : lo_en_q);
    end
  end

  rst_quiet_a: assert property (disable iff (1'b0) reset_i |=> !irq_o && lane_full_o == 2'h0)
    else $error("outputs not quiet after reset");
  csr_hold_a: assert property (!csr_rd_i |=> $stable(csr_rdata_o))
    else $error("control answer changed without a read");
  data_hold_a: assert property (!data_rd_i ##1 !data_rd_i |=> $stable(data_rdata_o))
    else $error("read data changed without a pop");
  split_status_a: assert property ($past(rd0) |-> csr_rdata_o[7] == $past(split_q))
    else $error("split bit wrong in status");
  ien_status_a: assert property ($past(rd0) |-> csr_rdata_o[4:3] == {$past(hi_en_q), $past(lo_en_q)})
    else $error("enable bits wrong in status");
  status_spare_a: assert property ($past(rd0) |-> csr_rdata_o[6:5] == 2'h0)
    else $error("unused status bits set");
  size_read_a: assert property ($past(rd1) |-> csr_rdata_o == 8'(BLOCKS))
    else $error("size byte wrong");
  irq_enable_a: assert property (irq_o |-> $past(hi_en_q) || $past(lo_en_q))
    else $error("interrupt with both enables clear");
  word_full_a: assert property (!split_q && !$past(split_q, 2) |-> lane_full_o[1] == lane_full_o[0])
    else $error("high full differs in word mode");
endmodule : dcf_input_fifo_asserts

bind dcf_input_fifo dcf_input_fifo_asserts #(.BLOCKS(BLOCKS)) chk (
  .clk_i(clk_i), .reset_i(reset_i), .lane_data_i(lane_data_i), .lane_write_clock_i(lane_write_clock_i),
  .lane_wrreq_i(lane_wrreq_i), .lane_reset_i(lane_reset_i), .lane_full_o(lane_full_o),
  .data_rd_i(data_rd_i), .data_lane_i(data_lane_i), .data_rdata_o(data_rdata_o),
  .csr_addr_i(csr_addr_i), .csr_rd_i(csr_rd_i), .csr_wr_i(csr_wr_i), .csr_wdata_i(csr_wdata_i),
  .csr_rdata_o(csr_rdata_o), .irq_o(irq_o)
);

// ===== bench/dcf_lane_writer.sv
// dcf_lane_writer: external write-side logic driving the lane pins.
// assumes: the bench calls put and kill; lane clocks idle low between writes.
`timescale 1ns/1ps
module dcf_lane_writer (
  input  wire logic [1:0]  lane_full_i,
  output logic      [15:0] lane_data_o,
  output logic      [1:0]  lane_write_clock_o,
  output logic      [1:0]  lane_wrreq_o,
  output logic      [1:0]  lane_reset_o
);
  initial
  begin
    lane_data_o        = 16'h0000;
    lane_write_clock_o = 2'h0;
    lane_wrreq_o       = 2'h0;
    lane_reset_o       = 2'h0;
  end

  // request and data held around one 62.5 ns clock pulse
  task automatic put(input int lane, input logic [15:0] d, input bit ovr);
    if (ovr || !lane_full_i[lane])
    begin
      lane_data_o        = d;
      lane_wrreq_o[lane] = 1'b1;
      #31.25 lane_write_clock_o[lane] = 1'b1;
      #62.5 lane_write_clock_o[lane] = 1'b0;
      lane_wrreq_o[lane] = 1'b0;
      lane_data_o        = ~d;
      #31.25;
    end
  endtask : put

  task automatic kill(input int lane);
    lane_reset_o[lane] = 1'b1;
    #100 lane_reset_o[lane] = 1'b0;
  endtask : kill
endmodule : dcf_lane_writer

// ===== bench/test_dcf_input_fifo.sv
// test_dcf_input_fifo: self-checking bench for the split-lane input queue.
// assumes: one block of storage (256 entries a lane), writer model on the pins.
`timescale 1ns/1ps
module test_dcf_input_fifo;
  typedef struct packed {logic [7:0] cmd; logic [7:0] sts;} dcf_row_t;
  localparam dcf_row_t ROWS [8] = '{'{8'h80, 8'h11}, '{8'h20, 8'h19}, '{8'h40, 8'h09}, '{8'h10, 8'h01},
                                    '{8'h08, 8'h81}, '{8'hC0, 8'h81}, '{8'h0C, 8'h01}, '{8'h03, 8'h01}};
  logic        clk_i, reset_i, data_rd_i, data_lane_i, csr_rd_i, csr_wr_i, irq_o;
  logic [15:0] lane_data, data_rdata_o, w;
  logic [1:0]  lane_clk, lane_req, lane_rst, lane_full_o, csr_addr_i;
  logic [7:0]  csr_wdata_i, csr_rdata_o, b;
  int          bad_count, checks, cycles;

  dcf_input_fifo #(.BLOCKS(1)) uut (
    .clk_i(clk_i), .reset_i(reset_i), .lane_data_i(lane_data), .lane_write_clock_i(lane_clk),
    .lane_wrreq_i(lane_req), .lane_reset_i(lane_rst), .lane_full_o(lane_full_o), .data_rd_i(data_rd_i),
    .data_lane_i(data_lane_i), .data_rdata_o(data_rdata_o), .csr_addr_i(csr_addr_i), .csr_rd_i(csr_rd_i),
    .csr_wr_i(csr_wr_i), .csr_wdata_i(csr_wdata_i), .csr_rdata_o(csr_rdata_o), .irq_o(irq_o));
  dcf_lane_writer writer (.lane_full_i(lane_full_o), .lane_data_o(lane_data), .lane_write_clock_o(lane_clk),
    .lane_wrreq_o(lane_req), .lane_reset_o(lane_rst));

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic results();
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // the whole run needs about 7000 cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      results();
    end
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk8

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk16

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    csr_wr_i    <= 1'b1;
    csr_addr_i  <= a;
    csr_wdata_i <= d;
    @(posedge clk_i);
    csr_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_i);
    csr_rd_i   <= 1'b1;
    csr_addr_i <= a;
    @(posedge clk_i);
    csr_rd_i <= 1'b0;
    #1 d = csr_rdata_o;
  endtask : rd

  task automatic pop(input logic l, output logic [15:0] d);
    @(posedge clk_i);
    data_rd_i   <= 1'b1;
    data_lane_i <= l;
    @(posedge clk_i);
    data_rd_i <= 1'b0;
    @(posedge clk_i);
    #1 d = data_rdata_o;
  endtask : pop

  initial
  begin
    {reset_i, data_rd_i, data_lane_i, csr_rd_i, csr_wr_i, csr_addr_i, csr_wdata_i} <= 15'h4000;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(2'h0, b);
    chk8(b, 8'h01);
    wr(2'h1, 8'h55);
    rd(2'h1, b);
    chk8(b, 8'h01);
    rd(2'h2, b);
    chk8(b, 8'h00);
    rd(2'h3, b);
    chk8(b, 8'h00);
    foreach (ROWS[i])
    begin
      wr(2'h0, ROWS[i].cmd);
      rd(2'h0, b);
      chk8(b, ROWS[i].sts);
    end
    wr(2'h0, 8'h20);
    #1 chk8({7'h00, irq_o}, 8'h00);
    for (int i = 0; i < 3; i++)
      writer.put(0, 16'hA0B0 + 16'(i), 1'b0);
    // word mode: a high-lane write must be ignored
    writer.put(1, 16'h7700, 1'b0);
    rd(2'h2, b);
    chk8(b, 8'h03);
    chk8({7'h00, irq_o}, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      pop(1'b0, w);
      chk16(w, 16'hA0B0 + 16'(i));
    end
    repeat (3) @(posedge clk_i);
    #1 chk8({7'h00, irq_o}, 8'h00);
    pop(1'b0, w);
    chk16(w, 16'hA0B2);
    for (int i = 0; i < 256; i++)
      writer.put(0, 16'(i), 1'b0);
    writer.put(0, 16'hFFFF, 1'b1);
    chk8({6'h00, lane_full_o}, 8'h03);
    rd(2'h0, b);
    chk8(b, 8'h0E);
    rd(2'h2, b);
    chk8(b, 8'hFF);
    pop(1'b0, w);
    chk16(w, 16'h0000);
    repeat (3) @(posedge clk_i);
    #1 chk8({7'h00, lane_full_o[0]}, 8'h00);
    writer.kill(0);
    repeat (4) @(posedge clk_i);
    rd(2'h2, b);
    chk8(b, 8'h00);
    rd(2'h0, b);
    chk8(b, 8'h09);
    // split mode, high enable on, low enable off
    wr(2'h0, 8'h98);
    writer.put(1, 16'h5A00, 1'b0);
    writer.put(1, 16'h6B00, 1'b0);
    writer.put(0, 16'h0011, 1'b0);
    writer.put(0, 16'h0022, 1'b0);
    rd(2'h0, b);
    chk8(b, 8'h97);
    chk8({7'h00, irq_o}, 8'h01);
    rd(2'h3, b);
    chk8(b, 8'h02);
    pop(1'b1, w);
    chk16(w, 16'h005A);
    wr(2'h0, 8'h02);
    rd(2'h3, b);
    chk8(b, 8'h00);
    chk8({7'h00, irq_o}, 8'h00);
    pop(1'b0, w);
    chk16(w, 16'h0011);
    pop(1'b0, w);
    chk16(w, 16'h0022);
    // mid-run reset must bring every output and control bit back to idle
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    #1 chk16(data_rdata_o, 16'h0000);
    rd(2'h0, b);
    chk8(b, 8'h01);
    results();
  end
endmodule : test_dcf_input_fifo
